// *** design/rtcc_defines.vh ***
// shared constants of the clock-output and compensation control block
// assumes: included by bare name, hclk at 200 MHz
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH

// ==========================================
// register indices (byte address = 4 * index)
`define RTCC_CFG_IDX 8'h13
`define RTCC_MISC_IDX 8'h14
`define RTCC_STAT_IDX 8'h15

// ==========================================
// clock_out_config fields
`define RTCC_TMP_HI 7
`define RTCC_TMP_LO 6
`define RTCC_CAL_BIT 5
`define RTCC_OFS_HI 2
`define RTCC_OFS_LO 0
`define RTCC_TMP_RST 2'b00
`define RTCC_OFS_RST 3'b000
`define RTCC_OFS_OFF 3'b111

// misc_ctl and status fields
`define RTCC_TCD_BIT 0
`define RTCC_SRST_BIT 1
`define RTCC_ACT_BIT 0
`define RTCC_BUSY_BIT 1

// ==========================================
// timing
`define RTCC_CLK_MHZ 200
`define RTCC_RELOAD_MAX_MS 100
`define RTCC_COMP_DELAY_S 60
`define RTCC_SEC_PER_MIN 60
`define RTCC_PER0_MIN 32
`define RTCC_PER1_MIN 16
`define RTCC_PER2_MIN 8
`define RTCC_PER3_MIN 4

`endif

// *** design/rtcc_sqw_div.v ***
// square-wave divider fed by the raw oscillator level
// assumes: osc_in is a level synchronous to hclk, far slower than hclk
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"

module rtcc_sqw_div (
	input wire hclk, // system clock
	input wire hresetn, // power-on reset, active low
	input wire ce, // clock enable
	input wire osc_in, // 32.768 kHz oscillator level
	input wire [2:0] sel, // frequency select code
	output reg osc_rise, // one-cycle pulse per oscillator period
	output reg sec_tick, // uncompensated one-second pulse
	output reg sqw_q, // square wave level
	output reg sqw_oen_n_q // high while the pin floats
);

	reg osc_q; // previous oscillator level
	reg [14:0] div_q; // binary ripple of the oscillator
	reg tap; // selected divider bit

	// ==========================================
	// divider chain
	// binary oscillator division
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_q <= 1'b0;
			div_q <= 15'h0000;
			osc_rise <= 1'b0;
			sec_tick <= 1'b0;
		end else if (ce) begin
			osc_q <= osc_in;
			osc_rise <= osc_in & ~osc_q;
			if (osc_in & ~osc_q) begin
				div_q <= div_q + 15'h0001;
			end
			sec_tick <= (osc_in & ~osc_q) & (&div_q);
		end
	end

	// ==========================================
	// tap selection
	// frequency code decode
	always @* begin
		case (sel)
			3'd0: tap = osc_q; // raw level, duty uncontrolled
			3'd1: tap = div_q[0];
			3'd2: tap = div_q[1];
			3'd3: tap = div_q[2];
			3'd4: tap = div_q[3];
			3'd5: tap = div_q[4];
			3'd6: tap = div_q[14];
			default: tap = 1'b0;
		endcase
	end

	// output stage
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sqw_q <= 1'b0;
			sqw_oen_n_q <= 1'b0;
		end else if (ce) begin
			sqw_q <= tap;
			sqw_oen_n_q <= (sel == `RTCC_OFS_OFF);
		end
	end

endmodule
`default_nettype wire

// *** design/rtcc_calib.v ***
// calibration reload sequencer, reset only by power-on
// assumes: wr_stb is a one-cycle register write with its bit value
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"

module rtcc_calib #(
	parameter RELOAD_CYC = 1024 // length of one copy in hclk cycles
) (
	input wire hclk, // system clock
	input wire hresetn, // power-on reset only
	input wire ce, // clock enable
	input wire wr_stb, // write strobe of the reload bit
	input wire wr_bit, // value written
	output reg done_q, // readback of the reload bit
	output wire busy // copy in progress
);

	localparam MAX_CYC = `RTCC_RELOAD_MAX_MS * `RTCC_CLK_MHZ * 1000;
	localparam ST_DONE = 1'b0;
	localparam ST_BUSY = 1'b1;

	reg state_q; // sequencer state
	reg wr_val_q; // last written bit value
	reg [24:0] cnt_q; // copy cycle counter
	wire cnt_end; // copy finished

	localparam integer END_CNT = RELOAD_CYC - 1; // last cycle of a normal copy
	localparam integer LIM_CNT = MAX_CYC - 2; // safety stop inside the time limit

	// bounded below the limit, counts cut to the counter width
	assign cnt_end = (cnt_q == END_CNT[24:0]) || (cnt_q == LIM_CNT[24:0]);
	assign busy = (state_q == ST_BUSY);

	// ==========================================
	// sequencer
	// power-on reset only
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// settles at power-on, kept by soft reset
			state_q <= ST_BUSY;
			wr_val_q <= 1'b1;
			done_q <= 1'b0;
			cnt_q <= 25'h000_0000;
		end else if (ce) begin
			if (wr_stb) begin
				wr_val_q <= wr_bit;
			end
			case (state_q)
				ST_DONE: begin
					if (wr_stb && wr_bit && !wr_val_q) begin
						state_q <= ST_BUSY;
						cnt_q <= 25'h000_0000;
						done_q <= 1'b0;
					end else if (wr_stb && !wr_bit) begin
						done_q <= 1'b0;
					end
				end
				ST_BUSY: begin
					// reads 0 until the copy ends
					cnt_q <= cnt_q + 25'h000_0001;
					if (cnt_end) begin
						state_q <= ST_DONE;
						done_q <= 1'b1;
					end
				end
				default: state_q <= ST_DONE;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** design/rtcc_clock_out_config.v ***
// clock-output and compensation control, AHB-Lite register slave
// assumes: single-word transfers, osc_in synchronous to hclk
// Behaviour
// - config register 0x13: period, reload, frequency
// - measurement period 32/16/8/4 minutes
// - first measurement right after power-on
// - compensation off for first 60 seconds
// - add or drop single pulses, evenly spread
// - correction step of one pulse per 32 seconds
// - reload starts on bit 0 to 1
// - reload bit reads 0 while copying
// - reload finishes under 100 ms
// - reload logic ignores soft reset
// - reload bit kept over soft resets
// - frequency select codes 000 to 111
// - code 111 floats the pin
// - push-pull output active from power-on
// - square wave uses uncorrected oscillator
// - divided frequencies have 50:50 duty
// - bits 4 and 3 read 0
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"

module rtcc_clock_out_config #(
	parameter RELOAD_CYC = 1024, // copy length in hclk cycles
	parameter SEC_PER_MIN = `RTCC_SEC_PER_MIN, // seconds per minute
	parameter COMP_DELAY_S = `RTCC_COMP_DELAY_S, // start-up delay
	parameter ACC_W = 20 // correction accumulator width
) (
	input wire hclk, // system clock
	input wire hresetn, // power-on reset, active low
	input wire ce, // clock enable, freezes state when low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write when high
	input wire [2:0] hsize, // transfer size
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output wire hreadyout, // slave ready
	output wire hresp, // always okay
	output reg [31:0] hrdata, // read data
	input wire osc_in, // 32.768 kHz oscillator level
	input wire signed [7:0] comp_value, // correction from sensor
	output reg temp_meas_req, // start one temperature measurement
	output reg rtc_tick, // compensated time divider input
	output reg comp_active, // compensation in effect
	output wire square_wave_out, // square wave pin data
	output wire square_wave_out_oen // low while driving the pin
);

	// ==========================================
	// declarations
	reg [1:0] temp_meas_period_sel_q; // period select
	reg [2:0] out_freq_sel_q; // frequency select
	reg temp_comp_disable_q; // compensation off
	reg soft_reset_cmd_q; // one-cycle soft reset
	reg [7:0] a_idx_q; // latched register index
	reg a_wr_q; // write data phase pending
	wire a_take; // address phase accepted
	wire cal_done; // reload bit readback
	wire cal_busy; // copy in progress
	wire osc_rise; // raw oscillator edge
	wire sec_tick; // raw one-second tick
	reg [11:0] per_sec_q; // seconds since last measurement
	reg [11:0] per_lim; // seconds in chosen period
	reg first_q; // first measurement still owed
	reg [7:0] dly_q; // start-up delay seconds
	reg [ACC_W-1:0] acc_q; // correction phase accumulator
	wire [ACC_W:0] acc_sum; // accumulator plus step
	reg [7:0] mag; // correction magnitude
	reg add_pend_q; // extra pulse still to insert
	reg [7:0] rd_mux; // read data of addressed register

	// ==========================================
	// derived constants
	// seconds per measurement period, cut to the counter width where used
	localparam integer PER0_SEC = `RTCC_PER0_MIN * SEC_PER_MIN; // 32 minute period
	localparam integer PER1_SEC = `RTCC_PER1_MIN * SEC_PER_MIN; // 16 minute period
	localparam integer PER2_SEC = `RTCC_PER2_MIN * SEC_PER_MIN; // 8 minute period
	localparam integer PER3_SEC = `RTCC_PER3_MIN * SEC_PER_MIN; // 4 minute period
	// last second of the start-up delay window
	localparam integer DLY_END = COMP_DELAY_S - 1;

	// ==========================================
	// bus slave
	// zero wait states: ready only drops while the enable freezes the block
	assign hreadyout = ce;
	assign hresp = 1'b0;
	// an address phase counts only when bus and enable are both ready
	assign a_take = hsel & htrans[1] & hready & ce;

	// address and data phase tracking
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_idx_q <= 8'h00;
			a_wr_q <= 1'b0;
		end else if (ce) begin
			a_wr_q <= a_take & hwrite;
			if (a_take) begin
				a_idx_q <= haddr[9:2];
			end
		end
	end

	// read data mux, unmapped reads as zero
	always @* begin
		rd_mux = 8'h00;
		case (haddr[9:2])
			`RTCC_CFG_IDX: begin
				rd_mux[`RTCC_TMP_HI:`RTCC_TMP_LO] = temp_meas_period_sel_q;
				rd_mux[`RTCC_CAL_BIT] = cal_done;
				rd_mux[`RTCC_OFS_HI:`RTCC_OFS_LO] = out_freq_sel_q;
			end
			`RTCC_MISC_IDX: begin
				rd_mux[`RTCC_TCD_BIT] = temp_comp_disable_q;
			end
			`RTCC_STAT_IDX: begin
				rd_mux[`RTCC_ACT_BIT] = comp_active;
				rd_mux[`RTCC_BUSY_BIT] = cal_busy;
			end
			default: rd_mux = 8'h00;
		endcase
	end

	// read data captured at the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			if (a_take && !hwrite) begin
				hrdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	// ==========================================
	// register writes
	// writes land at the end of the data phase, while hwdata stands
	// field placement at indices 0x13 and 0x14
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temp_meas_period_sel_q <= `RTCC_TMP_RST;
			out_freq_sel_q <= `RTCC_OFS_RST;
			temp_comp_disable_q <= 1'b0;
			soft_reset_cmd_q <= 1'b0;
		end else if (ce) begin
			soft_reset_cmd_q <= 1'b0;
			if (a_wr_q && a_idx_q == `RTCC_CFG_IDX) begin
				temp_meas_period_sel_q <= hwdata[`RTCC_TMP_HI:`RTCC_TMP_LO];
				out_freq_sel_q <= hwdata[`RTCC_OFS_HI:`RTCC_OFS_LO];
			end
			if (a_wr_q && a_idx_q == `RTCC_MISC_IDX) begin
				temp_comp_disable_q <= hwdata[`RTCC_TCD_BIT];
				soft_reset_cmd_q <= hwdata[`RTCC_SRST_BIT];
			end
		end
	end

	// ==========================================
	// calibration reload
	// a config write carries the reload bit along with the other fields
	// soft reset not connected here
	rtcc_calib #(
		.RELOAD_CYC(RELOAD_CYC)
	) u_calib (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.wr_stb(a_wr_q && a_idx_q == `RTCC_CFG_IDX),
		.wr_bit(hwdata[`RTCC_CAL_BIT]),
		.done_q(cal_done),
		.busy(cal_busy)
	);

	// ==========================================
	// square wave output
	// the divider taps the raw oscillator, so corrections never reach the pin
	rtcc_sqw_div u_sqw (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.osc_in(osc_in),
		.sel(out_freq_sel_q),
		.osc_rise(osc_rise),
		.sec_tick(sec_tick),
		.sqw_q(square_wave_out),
		.sqw_oen_n_q(square_wave_out_oen)
	);

	// ==========================================
	// temperature measurement schedule
	// period from the select field
	always @* begin
		case (temp_meas_period_sel_q)
			2'd0: per_lim = PER0_SEC[11:0];
			2'd1: per_lim = PER1_SEC[11:0];
			2'd2: per_lim = PER2_SEC[11:0];
			2'd3: per_lim = PER3_SEC[11:0];
			default: per_lim = PER0_SEC[11:0];
		endcase
	end

	// one-cycle request per period, first at once
	// raw seconds keep the schedule free of correction jitter
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_sec_q <= 12'h000;
			first_q <= 1'b1;
			temp_meas_req <= 1'b0;
		end else if (ce) begin
			temp_meas_req <= 1'b0;
			if (first_q) begin
				temp_meas_req <= 1'b1;
				first_q <= 1'b0;
				per_sec_q <= 12'h000;
			end else if (sec_tick) begin
				if (per_sec_q >= per_lim - 12'h001) begin
					temp_meas_req <= 1'b1;
					per_sec_q <= 12'h000;
				end else begin
					per_sec_q <= per_sec_q + 12'h001;
				end
			end
		end
	end

	// ==========================================
	// compensation start-up delay
	// inactive for the first seconds
	// the disable bit wins over the delay window in every cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dly_q <= 8'h00;
			comp_active <= 1'b0;
		end else if (ce) begin
			if (soft_reset_cmd_q) begin
				// soft reset restarts the delay window
				dly_q <= 8'h00;
				comp_active <= 1'b0;
			end else if (sec_tick && !comp_active) begin
				if (dly_q == DLY_END[7:0]) begin
					comp_active <= ~temp_comp_disable_q;
				end else begin
					dly_q <= dly_q + 8'h01;
				end
			end else if (temp_comp_disable_q) begin
				comp_active <= 1'b0;
			end
		end
	end

	// ==========================================
	// pulse add/delete engine
	// magnitude of the signed correction; the most negative code maps to 128
	always @* begin
		if (comp_value[7]) begin
			mag = -comp_value;
		end else begin
			mag = comp_value;
		end
	end

	assign acc_sum = {1'b0, acc_q} + {{(ACC_W-7){1'b0}}, mag};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= {ACC_W{1'b0}};
			add_pend_q <= 1'b0;
			rtc_tick <= 1'b0;
		end else if (ce) begin
			rtc_tick <= add_pend_q;
			add_pend_q <= 1'b0;
			// the accumulator only advances while compensation is active
			if (osc_rise) begin
				if (comp_active) begin
					acc_q <= acc_sum[ACC_W-1:0];
				end
				if (comp_active && acc_sum[ACC_W] && comp_value[7]) begin
					// negative correction drops this pulse
					// the time divider then runs one count short this period
					rtc_tick <= 1'b0;
				end else begin
					rtc_tick <= 1'b1;
				end
				// positive correction inserts one more
				add_pend_q <= comp_active & acc_sum[ACC_W] & ~comp_value[7];
			end
		end
	end

endmodule
`default_nettype wire

// *** bench/rtcc_ctl_props.sv ***
// concurrent checks on the ports of the clock-output control slave
// assumes: one hclk domain, hresetn is the power-on reset
`timescale 1ns/1ps
`default_nettype none
module rtcc_ctl_props (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, active low
	input wire logic ce, // clock enable
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic [31:0] hrdata, // read data
	input wire logic temp_meas_req, // measurement pulse
	input wire logic rtc_tick, // compensated tick
	input wire logic comp_active, // compensation on
	input wire logic square_wave_out, // pin data
	input wire logic square_wave_out_oen // pin float
);
	// ==========================================
	// helper decode
	wire logic cfg_hit = hsel & htrans[1] & hready & ce & (haddr[9:2] == 8'h13); // config access
	logic [3:0] cyc_q; // cycles since release, saturating
	// count edges after reset release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_q <= 4'h0;
		end else if (cyc_q != 4'hf) begin
			cyc_q <= cyc_q + 4'h1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_wr_off;
		cfg_hit & hwrite ##1 hwdata[2:0] == 3'h7;
	endsequence
	sequence s_wr_on;
		cfg_hit & hwrite ##1 hwdata[2:0] != 3'h7;
	endsequence
	// ==========================================
	// assertions
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_ready_ce: assert property (hreadyout == ce)
		else $error("ready does not follow enable");
	a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_unused_zero: assert property (cfg_hit & !hwrite |=> hrdata[4:3] == 2'b00)
		else $error("unused config bits read nonzero");
	a_float_low: assert property (square_wave_out_oen ##1 square_wave_out_oen |-> !square_wave_out)
		else $error("floating pin carries data");
	a_code_float: assert property (s_wr_off |-> ##[1:3] square_wave_out_oen)
		else $error("disable code did not float the pin");
	a_code_drive: assert property (s_wr_on |-> ##[1:3] !square_wave_out_oen)
		else $error("frequency code did not drive the pin");
	a_first_meas: assert property (cyc_q == 4'h1 |-> temp_meas_req)
		else $error("no measurement after reset");
	a_meas_single: assert property (temp_meas_req |=> !temp_meas_req)
		else $error("measurement pulse too long");
	a_tick_single: assert property (rtc_tick && !comp_active ##1 !comp_active |-> !rtc_tick)
		else $error("tick doubled without compensation");
	a_early_comp: assert property (cyc_q != 4'hf |-> !comp_active)
		else $error("compensation active right after reset");
endmodule
bind rtcc_clock_out_config rtcc_ctl_props u_props (.hclk(hclk), .hresetn(hresetn), .ce(ce),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.temp_meas_req(temp_meas_req), .rtc_tick(rtc_tick), .comp_active(comp_active),
	.square_wave_out(square_wave_out), .square_wave_out_oen(square_wave_out_oen));
`default_nettype wire

// *** bench/rtcc_sqw_sink.sv ***
// consumer of the square-wave pin: measures period and high time
// assumes: pin resolved by the bench, no pull, floats when released
`timescale 1ns/1ps
`default_nettype none
module rtcc_sqw_sink (
	input wire logic hclk, // sampling clock
	input wire logic pin, // resolved pin level
	output logic [15:0] period_q, // cycles between last two rises
	output logic [15:0] high_q // high cycles of that period
);
	logic prev_q = 1'b0; // pin one sample ago
	logic [15:0] cnt_q = 16'h0000; // cycles in this period
	logic [15:0] hcnt_q = 16'h0000; // high cycles in this period
	initial period_q = 16'h0000;
	initial high_q = 16'h0000;
	// measure each full period at the rising edge
	always @(posedge hclk) begin
		prev_q <= pin;
		if (pin === 1'b1 && prev_q === 1'b0) begin
			period_q <= cnt_q;
			high_q <= hcnt_q;
			cnt_q <= 16'h0001;
			hcnt_q <= 16'h0001;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			hcnt_q <= hcnt_q + {15'h0000, pin === 1'b1};
		end
	end
endmodule
`default_nettype wire

// *** bench/tb_rtcc_clock_out_config.sv ***
// self-checking bench for the clock-output control slave
// assumes: design sources and the bound checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"
module tb_rtcc_clock_out_config;
	localparam int RCYC = 16; // shortened copy length
	localparam int OSC_P = 4; // oscillator period in hclk cycles
	localparam logic [7:0] CFG = `RTCC_CFG_IDX; // config index
	logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [7:0] comp_value = 8'h00, idx;
	logic [3:0] osc_cnt = 4'h0; // oscillator phase
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
	wire logic hreadyout, hresp, temp_meas_req, rtc_tick, comp_active, sqw, sqw_oen, sqw_pin;
	wire logic [31:0] hrdata;
	wire logic [15:0] per, hi;
	int n_fail = 0, n_checks = 0, cycles = 0, seed = 32'h16d6_a06d, i, k;
	int n_meas = 0, n_tick = 0, t0; // pulse counters and a snapshot
	// one slave, no pull on the pin
	assign sqw_pin = sqw_oen ? 1'bz : sqw;
	initial forever #2.5 hclk = ~hclk;
	always @(posedge hclk) osc_cnt <= osc_cnt + 4'h1;
	rtcc_clock_out_config #(.RELOAD_CYC(RCYC), .SEC_PER_MIN(1), .COMP_DELAY_S(3)) dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.osc_in(osc_cnt[1]), .comp_value(comp_value), .temp_meas_req(temp_meas_req),
		.rtc_tick(rtc_tick), .comp_active(comp_active), .square_wave_out(sqw),
		.square_wave_out_oen(sqw_oen));
	rtcc_sqw_sink sink (.hclk(hclk), .pin(sqw_pin), .period_q(per), .high_q(hi));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// single word transfer, waits on ready in both phases
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, a, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// count measurement requests and time-divider ticks
	always @(posedge hclk) begin
		if (temp_meas_req === 1'b1) n_meas <= n_meas + 1;
		if (rtc_tick === 1'b1) n_tick <= n_tick + 1;
	end
	// hang guard
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(CFG, 32'h0000_0000);
		repeat (RCYC) @(posedge hclk);
		rd_chk(CFG, 32'h0000_0020);
		check(n_meas, 1);
		check({31'h0, comp_active}, 32'h0);
		$display("test reset values done");
		// every frequency code, random period bits and correction
		for (k = 0; k < 8; k++) begin
			i = $random(seed);
			comp_value <= i[15:8];
			// reload bit kept at 1, bit 4 kept clear
			xfer(1'b1, CFG, {24'h0, i[7:6], 2'b10, i[3], k[2:0]});
			rd_chk(CFG, {24'h0, i[7:6], 3'b100, k[2:0]});
			if (k < 6) begin
				repeat (3) @(posedge sqw_pin);
				repeat (2) @(posedge hclk);
				check({16'h0, per}, 32'(OSC_P << k));
				if (k > 0) check({16'h0, hi}, 32'(OSC_P << (k - 1)));
			end else begin
				check({30'h0, sqw_oen, sqw}, (k == 7) ? 32'h2 : 32'h0);
			end
		end
		$display("test frequency codes done");
		// host clears then sets the reload bit, then writes 1 again without a restart
		xfer(1'b1, CFG, 32'h0000_0000);
		rd_chk(CFG, 32'h0000_0000);
		xfer(1'b1, CFG, 32'h0000_0020);
		rd_chk(`RTCC_STAT_IDX, 32'h0000_0002);
		repeat (RCYC) @(posedge hclk);
		rd_chk(CFG, 32'h0000_0020);
		xfer(1'b1, CFG, 32'h0000_0020);
		rd_chk(`RTCC_STAT_IDX, 32'h0000_0000);
		// soft reset, then disable compensation at once
		xfer(1'b1, `RTCC_MISC_IDX, 32'h0000_0002);
		xfer(1'b1, `RTCC_MISC_IDX, 32'h0000_0001);
		rd_chk(`RTCC_MISC_IDX, 32'h0000_0001);
		rd_chk(CFG, 32'h0000_0020);
		// no correction pulses while compensation still waits
		t0 = n_tick;
		repeat (64) @(posedge hclk);
		check(n_tick - t0, 64 / OSC_P);
		check({31'h0, hresp}, 32'h0);
		$display("test reload and soft reset done");
		// free index is refused, read stalled by the enable
		i = $random(seed);
		idx = 8'h16 + {2'b00, i[5:0]};
		xfer(1'b1, idx, 32'hffff_ffff);
		ce <= 1'b0;
		fork
			begin
				repeat (4) @(posedge hclk);
				ce <= 1'b1;
			end
		join_none
		rd_chk(idx, 32'h0000_0000);
		// second power-on reset restarts copy and measurement
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(CFG, 32'h0000_0000);
		check(n_meas, 2);
		$display("test refusal and reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
